// >>> common/ibo_defs.vh
// constants for the interleaved pcm bus output block
`ifndef IBO_DEFS_VH
`define IBO_DEFS_VH
`define IBO_CTRL_OFFSET 9'h084
`define IBO_PORT_STRIDE 12'h200
`define IBO_ADDR_W 12
`define IBO_CTRL_RESET 8'h00
`define IBO_POS_LSB 0
`define IBO_POS_MSB 2
`define IBO_EN_BIT 3
`define IBO_MODE_BIT 4
`define IBO_SIZE_LSB 5
`define IBO_SIZE_MSB 6
`define IBO_SIZE_2DEV 2'h0
`define IBO_SIZE_4DEV 2'h1
`define IBO_SIZE_8DEV 2'h2
`define IBO_CNT_IDLE 12'h800
`define IBO_PORTS 8
`endif

// >>> rtl/ibo_sync.v
// three-stage input synchroniser with agreement filter
`timescale 1ns/10ps
module ibo_sync (
	input wire clk, // sampling clock
	input wire rst_n, // synchronised reset, low active
	input wire din, // asynchronous input
	output reg level_q, // filtered level
	output wire rise // one-cycle pulse on filtered rising edge
);
	reg s1_q;
	reg s2_q;
	reg s3_q;
	wire level_d;

	// level follows only once stages two and three agree
	assign level_d = (s2_q == s3_q) ? s2_q : level_q;
	assign rise = level_d & ~level_q;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
			level_q <= 1'b0;
		end else begin
			s1_q <= din;
			s2_q <= s1_q;
			s3_q <= s2_q;
			level_q <= level_d;
		end
	end
endmodule

// >>> rtl/ibo_top.v
// eight-port interleaved pcm bus output with control registers
`timescale 1ns/10ps
`include "ibo_defs.vh"
module ibo_top #(
	parameter PORTS = 8
) (
	input wire sys_clk, // 20 mhz system clock
	input wire rstn, // asynchronous reset, low active
	input wire bus_clk_in, // backplane bus clock pin
	input wire fsync_in, // 8 khz frame sync pin
	input wire reg_wr, // register write strobe, one cycle
	input wire reg_rd, // register read strobe, one cycle
	input wire [11:0] reg_addr, // register byte address
	input wire [7:0] reg_wdata, // register write data
	output reg [7:0] reg_rdata, // register read data
	input wire [8*PORTS-1:0] es_data, // elastic store head byte per port
	output reg [PORTS-1:0] es_rd, // elastic store advance pulse per port
	output reg [PORTS-1:0] pcm_out, // serial pcm data per port
	output reg [PORTS-1:0] bus_slot_output_enable // high while driving
);
	reg rst_s1_q;
	reg rst_s2_q;
	wire rst_n;
	wire bus_tick;
	wire fs_rise;
	reg [11:0] cnt_q;
	reg armed_q;
	reg armed_d;
	wire [11:0] cnt_nxt;
	wire [8*PORTS-1:0] ctrl_flat;
	reg [7:0] rdata_d;

	// register hit test: low bits match offset and port exists
	function hit;
		input [11:0] a;
		begin
			hit = (a[8:0] == `IBO_CTRL_OFFSET) && ({1'b0, a[11:9]} < PORTS);
		end
	endfunction

	// which device owns the bus at this bit count
	function [2:0] owner;
		input [11:0] c;
		input mode;
		input [1:0] size;
		reg [2:0] mask;
		begin
			mask = (size == `IBO_SIZE_2DEV) ? 3'h1 :
				(size == `IBO_SIZE_4DEV) ? 3'h3 : 3'h7;
			owner = mode ? (c[10:8] & mask) : (c[5:3] & mask);
		end
	endfunction

	// bit count lies inside the bus frame for this size
	function in_frame;
		input [11:0] c;
		input [1:0] size;
		begin
			case (size)
			`IBO_SIZE_2DEV: in_frame = (c[11:9] == 3'h0);
			`IBO_SIZE_4DEV: in_frame = (c[11:10] == 2'h0);
			`IBO_SIZE_8DEV: in_frame = ~c[11];
			default: in_frame = 1'b0;
			endcase
		end
	endfunction

	assign rst_n = rst_s2_q;

	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			rst_s1_q <= 1'b0;
			rst_s2_q <= 1'b0;
		end else begin
			rst_s1_q <= 1'b1;
			rst_s2_q <= rst_s1_q;
		end
	end

	ibo_sync u_bus_clk (
		.clk(sys_clk),
		.rst_n(rst_n),
		.din(bus_clk_in),
		.level_q(),
		.rise(bus_tick)
	);

	ibo_sync u_fsync (
		.clk(sys_clk),
		.rst_n(rst_n),
		.din(fsync_in),
		.level_q(),
		.rise(fs_rise)
	);

	// bit position counter relative to the common frame sync
	assign cnt_nxt = armed_q ? 12'h000 :
		(cnt_q[11] ? cnt_q : cnt_q + 12'h001);

	// a frame sync beside a bus edge keeps the restart pending
	always @* begin
		armed_d = armed_q;
		if (fs_rise) begin
			armed_d = 1'b1;
		end else if (bus_tick) begin
			armed_d = 1'b0;
		end
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= `IBO_CNT_IDLE;
			armed_q <= 1'b0;
		end else begin
			if (bus_tick) begin
				cnt_q <= cnt_nxt;
			end
			armed_q <= armed_d;
		end
	end

	// register read, unmapped addresses read zero
	always @* begin
		rdata_d = reg_rdata;
		if (reg_rd) begin
			rdata_d = 8'h00;
			if (hit(reg_addr)) begin
				rdata_d = ctrl_flat[8*reg_addr[11:9]+:8];
			end
		end
	end

	always @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= rdata_d;
		end
	end

	genvar i;
	generate
		for (i = 0; i < PORTS; i = i + 1) begin : g_port
			reg [7:0] ctrl_q;
			reg [6:0] shift_q;
			reg [6:0] shift_d;
			reg live_q;
			reg live_d;
			reg pcm_d;
			reg oe_d;
			reg rd_d;
			wire en;
			wire mine;
			wire wr_sel;
			wire start;

			assign ctrl_flat[8*i+:8] = ctrl_q;
			assign wr_sel = reg_wr && hit(reg_addr) && (reg_addr[11:9] == i);

			always @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					ctrl_q <= `IBO_CTRL_RESET;
				end else if (wr_sel) begin
					ctrl_q <= reg_wdata;
				end
			end

			assign en = ctrl_q[`IBO_EN_BIT];
			assign mine = en &&
				in_frame(cnt_nxt, ctrl_q[`IBO_SIZE_MSB:`IBO_SIZE_LSB]) &&
				(owner(cnt_nxt, ctrl_q[`IBO_MODE_BIT],
				ctrl_q[`IBO_SIZE_MSB:`IBO_SIZE_LSB]) ==
				ctrl_q[`IBO_POS_MSB:`IBO_POS_LSB]);

			// a slot is entered only on a byte boundary
			assign start = mine && (cnt_nxt[2:0] == 3'h0);

			// enabled mid-slot: stay quiet until the next own byte
			always @* begin
				shift_d = shift_q;
				live_d = live_q;
				pcm_d = pcm_out[i];
				oe_d = bus_slot_output_enable[i];
				rd_d = 1'b0;
				if (!en) begin
					live_d = 1'b0;
					pcm_d = 1'b0;
					oe_d = 1'b0;
				end else if (bus_tick) begin
					if (start) begin
						// take a fresh byte, store absorbs slips
						live_d = 1'b1;
						pcm_d = es_data[8*i+7];
						shift_d = es_data[8*i+:7];
						rd_d = 1'b1;
					end else if (mine && live_q) begin
						pcm_d = shift_q[6];
						shift_d = {shift_q[5:0], 1'b0};
					end else begin
						live_d = 1'b0;
						pcm_d = 1'b0;
					end
					oe_d = start || (mine && live_q);
				end
			end

			always @(posedge sys_clk or negedge rst_n) begin
				if (!rst_n) begin
					shift_q <= 7'h00;
					live_q <= 1'b0;
					pcm_out[i] <= 1'b0;
					bus_slot_output_enable[i] <= 1'b0;
					es_rd[i] <= 1'b0;
				end else begin
					shift_q <= shift_d;
					live_q <= live_d;
					pcm_out[i] <= pcm_d;
					bus_slot_output_enable[i] <= oe_d;
					es_rd[i] <= rd_d;
				end
			end
		end
	endgenerate
endmodule

// >>> testbench/ibo_sva.sv
// checker for the interleaved bus output block
`timescale 1ns/10ps
module ibo_sva #(
	parameter PORTS = 8
) (
	input wire sys_clk, // clock
	input wire rstn, // reset
	input wire reg_rd, // read
	input wire [11:0] reg_addr, // address
	input wire [7:0] reg_rdata, // read data
	input wire [PORTS-1:0] es_rd, // advance
	input wire [PORTS-1:0] pcm_out, // data
	input wire [PORTS-1:0] bus_slot_output_enable // enable
);
	wire e = bus_slot_output_enable[0];
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	bad_addr_a: assert property (
		reg_rd && reg_addr[8:0] != 9'h084 |=> reg_rdata == 8'h00)
		else $error("bad read");
	rdata_hold_a: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("read moved");
	quiet_idle_a: assert property (!e |-> !pcm_out[0])
		else $error("idle data");
	rd_in_slot_a: assert property (es_rd[0] |-> e)
		else $error("advance idle");
	rd_space_a: assert property (es_rd[0] |=> !es_rd[0] [*8])
		else $error("advance soon");
	slot_start_a: assert property ($rose(e) |-> es_rd[0] ##1 e [*7])
		else $error("slot start");
	slot_gap_a: assert property ($fell(e) |-> !e [*8])
		else $error("slot gap");
	port1_rd_a: assert property (es_rd[1] |-> bus_slot_output_enable[1])
		else $error("advance idle");
endmodule
bind ibo_top ibo_sva #(.PORTS(PORTS)) u_sva (.sys_clk(sys_clk), .rstn(rstn),
	.reg_rd(reg_rd), .reg_addr(reg_addr), .reg_rdata(reg_rdata),
	.es_rd(es_rd), .pcm_out(pcm_out),
	.bus_slot_output_enable(bus_slot_output_enable));

// >>> testbench/ibo_far.sv
// far side: backplane clock, frame sync, store heads
`timescale 1ns/10ps
module ibo_far #(
	parameter FB = 512
) (
	input wire sys_clk, // clock
	input wire [7:0] es_rd, // advance
	output reg bus_clk_in = 0, // free running
	output reg fsync_in = 0, // frame sync
	output wire [63:0] es_data, // heads
	output integer bitn = FB - 2 // bit begun at last rise
);
	reg [63:0] hd_q = 64'h3736353433323130;
	assign es_data = hd_q;
	initial forever #200 bus_clk_in = ~bus_clk_in;
	always @(posedge bus_clk_in) begin
		bitn <= (bitn == FB - 1) ? 0 : bitn + 1;
		fsync_in <= #50 (bitn == FB - 2);
	end
	always @(posedge sys_clk)
		for (int k = 0; k < 8; k++)
			if (es_rd[k]) hd_q[8*k +: 8] <= hd_q[8*k +: 8] + 8'h01;
endmodule

// >>> testbench/tb_top.sv
// testbench for the interleaved bus output block
`timescale 1ns/10ps
module tb_top;
	logic sys_clk = 0, rstn = 0, reg_wr = 0, reg_rd = 0;
	logic [11:0] reg_addr = 0;
	logic [7:0] reg_wdata = 0;
	wire [7:0] reg_rdata, es_rd, pcm_out, bus_slot_output_enable;
	wire [63:0] es_data;
	wire bus_clk_in, fsync_in;
	integer bitn;
	int fails = 0, n_tests = 0, cyc = 0, i;
	logic [15:0] rows [6] = '{16'h0809, 16'h1819, 16'h292b, 16'h4e4f,
		16'h0801, 16'h3839};
	ibo_top u_dut (.sys_clk(sys_clk), .rstn(rstn), .bus_clk_in(bus_clk_in),
		.fsync_in(fsync_in), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.es_data(es_data), .es_rd(es_rd), .pcm_out(pcm_out),
		.bus_slot_output_enable(bus_slot_output_enable));
	ibo_far u_far (.sys_clk(sys_clk), .es_rd(es_rd), .bus_clk_in(bus_clk_in),
		.fsync_in(fsync_in), .es_data(es_data), .bitn(bitn));
	initial forever #25 sys_clk = ~sys_clk;
	task close_out;
		if (fails == 0 && n_tests > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input string nm, input logic [7:0] got, exp);
		n_tests++;
		if (got !== exp) begin
			fails++;
			$display("MISMATCH %s exp %h got %h", nm, exp, got);
		end
	endtask
	task wr(input logic [11:0] a, input logic [7:0] d);
		@(posedge sys_clk) #5 reg_addr = a;
		reg_wdata = d;
		reg_wr = 1;
		@(posedge sys_clk) #5 reg_wr = 0;
	endtask
	task rd(input logic [11:0] a, input logic [7:0] d);
		@(posedge sys_clk) #5 reg_addr = a;
		reg_rd = 1;
		@(posedge sys_clk) #5 reg_rd = 0;
		@(posedge sys_clk) #5 chk("rdata", reg_rdata, d);
	endtask
	// follow ports 0 and 1 bit by bit from a frame start
	task frame(input logic [15:0] r);
		int p, n;
		logic [7:0] c, ex [2];
		logic own;
		do @(negedge bus_clk_in); while (bitn != 0);
		repeat (320) begin
			#195;
			for (p = 0; p < 2; p++) begin
				c = p ? r[7:0] : r[15:8];
				n = 2 << c[6:5];
				own = c[3] && c[6:5] != 2'h3 &&
					((bitn >> (c[4] ? 8 : 3)) & (n - 1)) == c[2:0];
				if (bitn % 8 == 0)
					ex[p] = es_data[8*p +: 8] - 8'h01;
				chk("oe", 8'(bus_slot_output_enable[p]), 8'(own));
				chk("pcm", 8'(pcm_out[p]), 8'(own & ex[p][7 - bitn % 8]));
			end
			@(negedge bus_clk_in);
		end
	endtask
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 80000) begin
			fails++;
			close_out;
		end
	end
	initial begin
		for (i = 0; i < 6; i++) begin
			@(posedge sys_clk) #5 rstn = 0;
			repeat (6) @(posedge sys_clk);
			#5 rstn = 1;
			repeat (2) @(posedge sys_clk);
			rd(12'h284, 8'h00);
			wr(12'h084, rows[i][15:8]);
			wr(12'h284, rows[i][7:0]);
			rd(12'h284, rows[i][7:0]);
			frame(rows[i]);
		end
		wr(12'he84, 8'h4d);
		rd(12'he84, 8'h4d);
		wr(12'h085, 8'hff);
		rd(12'h085, 8'h00);
		rd(12'h084, rows[5][15:8]);
		close_out;
	end
endmodule
